// ===== pkg/i2ctw_pkg.sv
// Shared constants, types and address decode for the two-wire target link
package i2ctw_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ         = 10_000_000;
	localparam int CLK_MHZ        = CLK_HZ / 1_000_000;
	localparam int SCL_MAX_HZ     = 400_000;
	// Quarter bit period, rounded up so the bit rate never exceeds the maximum
	localparam logic [2:0] SCL_QTR = 3'((CLK_HZ / SCL_MAX_HZ + 3) / 4);
	localparam int STRETCH_MIN_US = 60;
	localparam int STRETCH_MAX_US = 128;
	localparam logic [9:0] STRETCH_CYC = 10'(STRETCH_MIN_US * CLK_MHZ);
	localparam int LOOP_MAX_US    = 1000;

	// ----------------------------------------------------------------
	// Framing and addresses
	// ----------------------------------------------------------------
	localparam logic [3:0] ACK_BIT   = 4'h8;
	localparam logic [3:0] MSB_BIT   = 4'h7;
	localparam logic [6:0] ADDR_DEF  = 7'h44;
	localparam logic [6:0] ADDR_ALT  = 7'h45;
	localparam logic [6:0] ADDR_GND  = 7'h02;
	localparam logic       RW_WRITE  = 1'b0;
	localparam logic       RW_READ   = 1'b1;
	localparam logic [1:0] IDX_ADDR  = 2'h0;
	localparam logic [1:0] IDX_CMD   = 2'h1;
	localparam logic [1:0] IDX_LAST  = 2'h3;
	localparam logic [1:0] IDX_RLAST = 2'h2;

	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_ADDR = 3'b001,
		T_ACK  = 3'b010,
		T_HOLD = 3'b011,
		T_RX   = 3'b100,
		T_TX   = 3'b101,
		T_MACK = 3'b110
	} i2ctw_tstate_e;

	typedef enum logic [2:0] {
		M_IDLE   = 3'b000,
		M_START  = 3'b001,
		M_BIT    = 3'b010,
		M_RSTART = 3'b011,
		M_STOP   = 3'b100
	} i2ctw_mstate_e;

	// Bus address from variant and strap level; grounded strap adds two
	function automatic logic [6:0] i2ctw_addr(input logic alt, input logic strap_used,
						  input logic strap_level);
		logic [6:0] a;
		a = alt ? ADDR_ALT : ADDR_DEF;
		if (strap_used && !strap_level)
			a = a + ADDR_GND;
		return a;
	endfunction : i2ctw_addr
endpackage : i2ctw_pkg

// ===== pkg/i2ctw_if.sv
// Open-drain two-wire bus plus ready line joining master and target
`timescale 1ns/10ps
interface i2ctw_if;
	logic m_scl_oe;
	logic m_sda_oe;
	logic t_scl_oe;
	logic t_sda_oe;
	logic t_rdy_oe;
	logic scl;
	logic sda;
	logic rdy_n;

	// Pulled-up wires: any enabled driver pulls low
	assign scl   = ~(m_scl_oe | t_scl_oe);
	assign sda   = ~(m_sda_oe | t_sda_oe);
	assign rdy_n = ~t_rdy_oe;

	modport target (input scl, input sda, output t_scl_oe, output t_sda_oe, output t_rdy_oe);
	modport master (input scl, input sda, input rdy_n, output m_scl_oe, output m_sda_oe);
endinterface : i2ctw_if

// ===== verilog/i2ctw_target.sv
// Two-wire target with communication windows, clock stretching and word register map
`timescale 1ns/10ps
module i2ctw_target
	import i2ctw_pkg::*;
#(
	parameter int unsigned LOOP_CYC = i2ctw_pkg::LOOP_MAX_US * i2ctw_pkg::CLK_MHZ
)(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Bus
	i2ctw_if.target          bus,
	// Window sources
	input  wire logic        stream_mode,
	input  wire logic        sample_tick,
	input  wire logic        event_in,
	output logic             window_open,
	// Address selection
	input  wire logic        alt_variant,
	input  wire logic        strap_is_input,
	input  wire logic        strap_drive,
	input  wire logic        address_strap_pin_in,
	output logic             address_strap_pin_oe,
	output logic             address_strap_pullup_en,
	// Register map load from the sensor side
	input  wire logic        load_en,
	input  wire logic [7:0]  load_addr,
	input  wire logic [15:0] load_data,
	// Words written by the master
	output logic             wr_valid,
	output logic [7:0]       wr_addr,
	output logic [15:0]      wr_data
);
	import i2ctw_pkg::*;

	// ----------------------------------------------------------------
	// Line sampling and conditions
	// ----------------------------------------------------------------
	logic scl_q, sda_q;
	logic scl_rise, scl_fall, start_det, stop_det;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= bus.scl;
			sda_q <= bus.sda;
		end

	assign scl_rise  = bus.scl & ~scl_q;
	assign scl_fall  = ~bus.scl & scl_q;
	assign start_det = bus.scl & scl_q & sda_q & ~bus.sda;
	assign stop_det  = bus.scl & scl_q & ~sda_q & bus.sda;

	// ----------------------------------------------------------------
	// Address selection
	// ----------------------------------------------------------------
	logic [6:0] addr_q;
	logic       pullup_q, strap_oe_q;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			addr_q     <= ADDR_DEF;
			pullup_q   <= 1'b0;
			strap_oe_q <= 1'b0;
		end
		else
		begin
			addr_q     <= i2ctw_addr(alt_variant, strap_is_input, address_strap_pin_in);
			pullup_q   <= strap_is_input;
			strap_oe_q <= ~strap_is_input & strap_drive;
		end

	// ----------------------------------------------------------------
	// Target state machine
	// ----------------------------------------------------------------
	i2ctw_tstate_e state_q, nxt_q;
	logic [7:0]    sh_q, ptr_q, rd_byte;
	logic [3:0]    bit_cnt_q;
	logic [9:0]    tmr_q;
	logic          off_q, rw_q, is_addr_q, cmd_pend_q, hold_win_q;
	logic          scl_oe_q, sda_oe_q, win_q, acc_q;
	logic [15:0]   mem [256];
	logic          rx_done, data_stb;

	assign rd_byte  = off_q ? mem[ptr_q][15:8] : mem[ptr_q][7:0];
	assign rx_done  = scl_fall && bit_cnt_q == ACK_BIT;
	assign data_stb = state_q == T_RX && rx_done && !cmd_pend_q;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			state_q    <= T_IDLE;
			nxt_q      <= T_IDLE;
			sh_q       <= 8'h00;
			bit_cnt_q  <= 4'h0;
			tmr_q      <= 10'h000;
			rw_q       <= RW_WRITE;
			is_addr_q  <= 1'b0;
			cmd_pend_q <= 1'b0;
			hold_win_q <= 1'b0;
			scl_oe_q   <= 1'b0;
			sda_oe_q   <= 1'b0;
		end
		else if (start_det)
		begin
			// Start or repeated start from any state
			state_q   <= T_ADDR;
			bit_cnt_q <= 4'h0;
			scl_oe_q  <= 1'b0;
			sda_oe_q  <= 1'b0;
		end
		else if (stop_det)
		begin
			state_q  <= T_IDLE;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			case (state_q)
				T_ADDR, T_RX:
				begin
					if (scl_rise)
					begin
						sh_q      <= {sh_q[6:0], bus.sda};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					else if (rx_done)
					begin
						is_addr_q <= state_q == T_ADDR;
						if (state_q == T_ADDR && sh_q[7:1] != addr_q)
							state_q <= T_IDLE;
						else
						begin
							// address acked whether or not a window is open
							state_q  <= T_ACK;
							sda_oe_q <= 1'b1;
							if (state_q == T_ADDR)
								rw_q <= sh_q[0];
						end
					end
				end
				T_ACK:
				begin
					if (scl_fall)
					begin
						sda_oe_q  <= 1'b0;
						bit_cnt_q <= 4'h0;
						if (is_addr_q)
						begin
							cmd_pend_q <= rw_q == RW_WRITE;
							nxt_q      <= rw_q == RW_READ ? T_TX : T_RX;
							state_q    <= T_HOLD;
							scl_oe_q   <= 1'b1;
							hold_win_q <= 1'b1;
						end
						else if (cmd_pend_q)
						begin
							// Buffer load time after a fresh command byte
							cmd_pend_q <= 1'b0;
							nxt_q      <= T_RX;
							state_q    <= T_HOLD;
							scl_oe_q   <= 1'b1;
							hold_win_q <= 1'b0;
							tmr_q      <= STRETCH_CYC - 10'h001;
						end
						else
							state_q <= T_RX;
					end
				end
				T_HOLD:
				begin
					if (tmr_q != 10'h000)
						tmr_q <= tmr_q - 10'h001;
					if (hold_win_q ? win_q : tmr_q == 10'h000)
					begin
						scl_oe_q <= 1'b0;
						state_q  <= nxt_q;
						if (nxt_q == T_TX)
						begin
							sh_q     <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
						end
					end
				end
				T_TX:
				begin
					if (scl_rise)
						bit_cnt_q <= bit_cnt_q + 4'h1;
					else if (rx_done)
					begin
						sda_oe_q <= 1'b0;
						state_q  <= T_MACK;
					end
					else if (scl_fall)
					begin
						sh_q     <= {sh_q[6:0], 1'b0};
						sda_oe_q <= ~sh_q[6];
					end
				end
				T_MACK:
				begin
					if (scl_rise && bus.sda)
						state_q <= T_IDLE;
					else if (scl_fall)
					begin
						state_q   <= T_TX;
						bit_cnt_q <= 4'h0;
						sh_q      <= rd_byte;
						sda_oe_q  <= ~rd_byte[7];
					end
				end
				default:
					state_q <= T_IDLE;
			endcase
		end

	// ----------------------------------------------------------------
	// Pointer and byte offset
	// ----------------------------------------------------------------
	logic adv_off;

	// Offset advances after every data byte, in either direction
	assign adv_off = data_stb || (state_q == T_TX && rx_done);

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			ptr_q <= 8'h00;
			off_q <= 1'b0;
		end
		else if (state_q == T_RX && rx_done && cmd_pend_q)
		begin
			ptr_q <= sh_q;
			off_q <= 1'b0;
		end
		else if (adv_off)
		begin
			off_q <= ~off_q;
			if (off_q)
				ptr_q <= ptr_q + 8'h01;
		end

	// ----------------------------------------------------------------
	// Register map storage
	// ----------------------------------------------------------------
	// Sensor-side load wins a same-cycle collision; the master's byte is lost
	always_ff @(posedge clk)
		if (load_en)
			mem[load_addr] <= load_data;
		else if (data_stb && !off_q)
			mem[ptr_q][7:0] <= sh_q;
		else if (data_stb)
			mem[ptr_q][15:8] <= sh_q;

	logic        wr_valid_q;
	logic [7:0]  wr_addr_q, lo_q;
	logic [15:0] wr_data_q;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			wr_valid_q <= 1'b0;
			wr_addr_q  <= 8'h00;
			wr_data_q  <= 16'h0000;
			lo_q       <= 8'h00;
		end
		else
		begin
			wr_valid_q <= data_stb && off_q;
			if (data_stb && !off_q)
				lo_q <= sh_q;
			if (data_stb && off_q)
			begin
				wr_addr_q <= ptr_q;
				wr_data_q <= {sh_q, lo_q};
			end
		end

	// ----------------------------------------------------------------
	// Communication window
	// ----------------------------------------------------------------
	logic [15:0] pend_q;
	logic        open_req, force_open;

	assign open_req   = stream_mode ? sample_tick : event_in;
	assign force_open = pend_q == 16'(LOOP_CYC - 1);

	// Unsolicited access waiting for a window is serviced by the loop check
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			pend_q <= 16'h0000;
		else if (state_q == T_HOLD && hold_win_q && !win_q && !force_open)
			pend_q <= pend_q + 16'h0001;
		else
			pend_q <= 16'h0000;

	// An opening request in the closing cycle wins over the close
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			win_q <= 1'b0;
			acc_q <= 1'b0;
		end
		else
		begin
			if (open_req || force_open)
				win_q <= 1'b1;
			else if (stop_det && acc_q)
				win_q <= 1'b0;
			if (stop_det && win_q)
				acc_q <= 1'b0;
			else if (state_q == T_ACK && is_addr_q)
				acc_q <= 1'b1;
		end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.t_scl_oe            = scl_oe_q;
	assign bus.t_sda_oe            = sda_oe_q;
	assign bus.t_rdy_oe            = win_q;
	assign window_open             = win_q;
	assign address_strap_pin_oe    = strap_oe_q;
	assign address_strap_pullup_en = pullup_q;
	assign wr_valid                = wr_valid_q;
	assign wr_addr                 = wr_addr_q;
	assign wr_data                 = wr_data_q;
endmodule : i2ctw_target

// ===== verilog/i2ctw_master.sv
// Bus master end: word writes, current-address reads and random reads
`timescale 1ns/10ps
module i2ctw_master
	import i2ctw_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Bus
	i2ctw_if.master          bus,
	// Request
	input  wire logic        cmd_valid,
	input  wire logic        cmd_rw,
	input  wire logic        cmd_new_addr,
	input  wire logic [6:0]  cmd_dev,
	input  wire logic [7:0]  cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	output logic             cmd_ready,
	// Answer
	output logic             rsp_valid,
	output logic             rsp_nack,
	output logic [15:0]      rsp_data,
	output logic             window_seen
);
	import i2ctw_pkg::*;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	i2ctw_mstate_e state_q;
	logic [2:0]    cnt_q;
	logic [1:0]    ph_q, idx_q;
	logic [3:0]    bit_q;
	logic [7:0]    rx_q, tx_byte;
	logic [15:0]   wd_q, rd_q;
	logic [7:0]    ad_q;
	logic [6:0]    dev_q;
	logic          rw_q, seg_q, scl_oe_q, sda_oe_q, nack_q;
	logic          ready_q, rsp_q, win_q, tick, sending, last;

	assign tick    = cnt_q == 3'h0;
	// Command byte always follows the control byte on a write segment
	assign tx_byte = idx_q == IDX_ADDR ? {dev_q, seg_q} :
			 idx_q == IDX_CMD  ? ad_q :
			 idx_q == IDX_RLAST ? wd_q[7:0] : wd_q[15:8];
	assign sending = !seg_q || idx_q == IDX_ADDR;
	assign last    = seg_q ? idx_q == IDX_RLAST : (rw_q ? idx_q == IDX_CMD : idx_q == IDX_LAST);

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cnt_q <= 3'h0;
		else
			cnt_q <= tick ? SCL_QTR - 3'h1 : cnt_q - 3'h1;

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			state_q  <= M_IDLE;
			ph_q     <= 2'h0;
			idx_q    <= 2'h0;
			bit_q    <= 4'h0;
			rx_q     <= 8'h00;
			wd_q     <= 16'h0000;
			rd_q     <= 16'h0000;
			ad_q     <= 8'h00;
			dev_q    <= ADDR_DEF;
			rw_q     <= RW_WRITE;
			seg_q    <= RW_WRITE;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			nack_q   <= 1'b0;
			ready_q  <= 1'b1;
			rsp_q    <= 1'b0;
		end
		else
		begin
			rsp_q <= 1'b0;
			if (state_q == M_IDLE && cmd_valid && ready_q)
			begin
				ready_q <= 1'b0;
				state_q <= M_START;
				ph_q    <= 2'h0;
				dev_q   <= cmd_dev;
				ad_q    <= cmd_addr;
				wd_q    <= cmd_wdata;
				rw_q    <= cmd_rw;
				// A read with no new command starts at the stored pointer
				seg_q   <= cmd_rw && !cmd_new_addr;
				nack_q  <= 1'b0;
			end
			else if (tick && state_q != M_IDLE)
			begin
				// Stretching: wait in the high phase until the line really rises
				if (!(ph_q == 2'h2 && !bus.scl))
					ph_q <= ph_q + 2'h1;
				case (state_q)
					M_START, M_RSTART:
					begin
						if (ph_q == 2'h0)
							sda_oe_q <= state_q == M_START;
						else if (ph_q == 2'h1)
							scl_oe_q <= 1'b0;
						else if (ph_q == 2'h2 && bus.scl)
							sda_oe_q <= 1'b1;
						else if (ph_q == 2'h3)
						begin
							scl_oe_q <= 1'b1;
							state_q  <= M_BIT;
							idx_q    <= IDX_ADDR;
							bit_q    <= 4'h0;
						end
					end
					M_BIT:
					begin
						if (ph_q == 2'h0)
						begin
							if (bit_q != ACK_BIT)
								sda_oe_q <= sending & ~tx_byte[MSB_BIT[2:0] - bit_q[2:0]];
							else
								sda_oe_q <= !sending && !last;
						end
						else if (ph_q == 2'h1)
							scl_oe_q <= 1'b0;
						else if (ph_q == 2'h2 && bus.scl)
						begin
							if (bit_q != ACK_BIT)
								rx_q <= {rx_q[6:0], bus.sda};
							else if (sending)
								nack_q <= bus.sda;
						end
						else if (ph_q == 2'h3)
						begin
							scl_oe_q <= 1'b1;
							bit_q    <= bit_q + 4'h1;
							if (bit_q == ACK_BIT)
							begin
								bit_q <= 4'h0;
								idx_q <= idx_q + 2'h1;
								if (!sending && idx_q == IDX_CMD)
									rd_q[7:0] <= rx_q;
								if (!sending && idx_q == IDX_RLAST)
									rd_q[15:8] <= rx_q;
								if (nack_q || (last && (seg_q || !rw_q)))
									state_q <= M_STOP;
								else if (last)
								begin
									// Random read: command written, then turn round
									state_q <= M_RSTART;
									seg_q   <= RW_READ;
								end
							end
						end
					end
					M_STOP:
					begin
						if (ph_q == 2'h0)
							sda_oe_q <= 1'b1;
						else if (ph_q == 2'h1)
							scl_oe_q <= 1'b0;
						else if (ph_q == 2'h3)
						begin
							sda_oe_q <= 1'b0;
							state_q  <= M_IDLE;
							ready_q  <= 1'b1;
							rsp_q    <= 1'b1;
						end
					end
					default:
						state_q <= M_IDLE;
				endcase
			end
		end

	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			win_q <= 1'b0;
		else
			win_q <= ~bus.rdy_n;

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.m_scl_oe = scl_oe_q;
	assign bus.m_sda_oe = sda_oe_q;
	assign cmd_ready    = ready_q;
	assign rsp_valid    = rsp_q;
	assign rsp_nack     = nack_q;
	assign rsp_data     = rd_q;
	assign window_seen  = win_q;
endmodule : i2ctw_master

// ===== dv/i2ctw_monitor.sv
// Concurrent checks on the open-drain link between master and target
`timescale 1ns/10ps
module i2ctw_monitor
#(
	parameter int unsigned LOOP_CYC = 50
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Link enables and wired levels
	input wire logic m_scl_oe,
	input wire logic t_scl_oe,
	input wire logic t_sda_oe,
	input wire logic t_rdy_oe,
	input wire logic scl,
	input wire logic sda
);
	// ----------------------------------------------------------------
	// Helper state
	// ----------------------------------------------------------------
	// Longest legal hold: 128 us at 10 MHz, or the forced-window wait if longer
	localparam int HOLD_MAX = (LOOP_CYC > 1280) ? int'(LOOP_CYC) + 8 : 1280;
	logic scl_q;
	logic sda_q;
	int   stop_age;
	int   hold_cnt;
	int   wait_cnt;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			stop_age <= 255;
			hold_cnt <= 0;
			wait_cnt <= 0;
		end
		else
		begin
			scl_q    <= scl;
			sda_q    <= sda;
			stop_age <= (scl_q && scl && !sda_q && sda) ? 0 : (stop_age < 255 ? stop_age + 1 : 255);
			hold_cnt <= t_scl_oe ? hold_cnt + 1 : 0;
			wait_cnt <= (t_scl_oe && !t_rdy_oe) ? wait_cnt + 1 : 0;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_rdy_close_stop: assert property ($fell(t_rdy_oe) |-> stop_age <= 8)
		else $error("ready line released away from a stop");
	a_sda_hold_high: assert property (scl && $past(scl) |-> $stable(t_sda_oe))
		else $error("target moved data while clock high");
	a_hold_from_low: assert property ($rose(t_scl_oe) |-> !$past(scl))
		else $error("target grabbed clock while it was high");
	a_hold_bound: assert property (t_scl_oe |-> hold_cnt <= HOLD_MAX)
		else $error("clock held low too long");
	a_wait_window: assert property (t_scl_oe && !t_rdy_oe |-> wait_cnt <= LOOP_CYC + 8)
		else $error("window not forced open in time");
	a_idle_after_rst: assert property ($rose(rst_n) |-> !t_scl_oe && !t_sda_oe && !t_rdy_oe)
		else $error("target drives a line out of reset");
	a_release_in_window: assert property ($fell(t_scl_oe) |-> t_rdy_oe)
		else $error("clock released outside a window");
	a_grab_master_low: assert property ($rose(t_scl_oe) |-> $past(m_scl_oe))
		else $error("target grabbed clock the master had released");
	a_rdy_min_open: assert property ($rose(t_rdy_oe) |=> t_rdy_oe [*4])
		else $error("ready line glitched");
endmodule : i2ctw_monitor

// ===== dv/testbench.sv
// Self-checking bench: master and target joined over the two-wire link
`timescale 1ns/10ps
module testbench;
	import i2ctw_pkg::*;
	logic clk;
	logic rst_n;
	logic stream_mode, sample_tick, event_in, window_open, win_seen;
	logic alt_variant, strap_is_input, strap_drive, strap_gnd, strap_oe, pullup_en;
	logic load_en;
	logic [7:0] load_addr;
	logic [15:0] load_data;
	logic wr_valid;
	logic [7:0] wr_addr, wa;
	logic [15:0] wr_data, wd;
	logic cmd_valid, cmd_rw, cmd_new_addr, cmd_ready, rsp_valid, rsp_nack;
	logic [6:0] cmd_dev;
	logic [7:0] cmd_addr;
	logic [15:0] cmd_wdata, rsp_data;
	int mismatches, comparisons, cycles, wr_cnt, run, max_run;
	// Each entry: variant, strap-as-input, strap grounded, expected address
	logic [9:0] tbl [6] = '{10'h044, 10'h144, 10'h1c6, 10'h2c5, 10'h345, 10'h3c7};

	// ----------------------------------------------------------------
	// Structure
	// ----------------------------------------------------------------
	i2ctw_if link ();
	// Pin has a pull-up; grounded or driven low reads 0
	wire strap_pin = ~(strap_oe | strap_gnd);

	i2ctw_target #(.LOOP_CYC(50)) i_i2ctw_target (.clk(clk), .rst_n(rst_n), .bus(link),
		.stream_mode(stream_mode), .sample_tick(sample_tick), .event_in(event_in),
		.window_open(window_open), .alt_variant(alt_variant), .strap_is_input(strap_is_input),
		.strap_drive(strap_drive), .address_strap_pin_in(strap_pin),
		.address_strap_pin_oe(strap_oe), .address_strap_pullup_en(pullup_en),
		.load_en(load_en), .load_addr(load_addr), .load_data(load_data),
		.wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data));
	i2ctw_master i_i2ctw_master (.clk(clk), .rst_n(rst_n), .bus(link), .cmd_valid(cmd_valid),
		.cmd_rw(cmd_rw), .cmd_new_addr(cmd_new_addr), .cmd_dev(cmd_dev), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_nack(rsp_nack), .rsp_data(rsp_data), .window_seen(win_seen));
	i2ctw_monitor #(.LOOP_CYC(50)) u_mon (.clk(clk), .rst_n(rst_n), .m_scl_oe(link.m_scl_oe),
		.t_scl_oe(link.t_scl_oe), .t_sda_oe(link.t_sda_oe), .t_rdy_oe(link.t_rdy_oe),
		.scl(link.scl), .sda(link.sda));

	// ----------------------------------------------------------------
	// Clock, watchers and timeout
	// ----------------------------------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cycles++;
		run = (link.t_scl_oe === 1'b1) ? run + 1 : 0;
		max_run = (run > max_run) ? run : max_run;
		if (wr_valid === 1'b1)
		begin
			wr_cnt++;
			wa = wr_addr;
			wd = wr_data;
		end
		if (cycles == 80000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		$display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic xfer(input logic rw, input logic na, input logic [6:0] dev,
		input logic [7:0] a, input logic [15:0] d);
		int n;
		@(negedge clk);
		while (cmd_ready !== 1'b1)
			@(negedge clk);
		cmd_valid = 1'b1;
		cmd_rw = rw;
		cmd_new_addr = na;
		cmd_dev = dev;
		cmd_addr = a;
		cmd_wdata = d;
		// Master is idle and ready, so the rising edge in between takes it
		@(negedge clk);
		cmd_valid = 1'b0;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 20000);
		if (rsp_valid !== 1'b1)
		begin
			mismatches++;
			$display("ERROR t=%0t no response got=%h exp=%h", $time, rsp_valid, 1'b1);
		end
		repeat (4) @(negedge clk);
	endtask : xfer

	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		repeat (2) @(posedge clk);
	endtask : pulse

	// Window closed: address still taken, window forced, word delivered
	task automatic t_write_forced();
		wr_cnt = 0;
		xfer(RW_WRITE, 1'b0, 7'h44, 8'h10, 16'hbbaa);
		chk(rsp_nack, 1'b0);
		chk(wr_cnt, 16'h1);
		chk(wa, 8'h10);
		chk(wd, 16'hbbaa);
		chk(window_open, 1'b0);
	endtask : t_write_forced

	// Event window, random read with command stretch, then current read
	task automatic t_reads();
		@(negedge clk);
		load_en = 1'b1;
		load_addr = 8'h20;
		load_data = 16'h1234;
		@(negedge clk);
		load_addr = 8'h21;
		load_data = 16'h5678;
		@(negedge clk);
		load_en = 1'b0;
		pulse(event_in);
		chk(window_open, 1'b1);
		chk(link.rdy_n, 1'b0);
		chk(win_seen, 1'b1);
		max_run = 0;
		xfer(RW_READ, 1'b1, 7'h44, 8'h20, 16'h0);
		chk(rsp_data, 16'h1234);
		chk(max_run >= 600 && max_run <= 1280, 1'b1);
		xfer(RW_READ, 1'b0, 7'h44, 8'h0, 16'h0);
		chk(rsp_data, 16'h5678);
		chk(link.rdy_n, 1'b1);
	endtask : t_reads

	// Streaming window closes at the stop of an addressed write
	task automatic t_stream();
		stream_mode = 1'b1;
		pulse(sample_tick);
		chk(window_open, 1'b1);
		xfer(RW_WRITE, 1'b0, 7'h44, 8'h30, 16'h00ff);
		chk(wd, 16'h00ff);
		chk(window_open, 1'b0);
		stream_mode = 1'b0;
	endtask : t_stream

	// Every address option answers on its own address and not on the address two away (bit 1 flipped)
	task automatic t_addr();
		@(negedge clk);
		strap_drive = 1'b1;
		@(negedge clk);
		chk(strap_oe, 1'b1);
		strap_drive = 1'b0;
		foreach (tbl[i])
		begin
			@(negedge clk);
			{alt_variant, strap_is_input, strap_gnd} = tbl[i][9:7];
			repeat (2) @(posedge clk);
			chk(pullup_en, strap_is_input);
			xfer(RW_WRITE, 1'b0, tbl[i][6:0] ^ 7'h02, 8'h40, 16'h0);
			chk(rsp_nack, 1'b1);
			xfer(RW_WRITE, 1'b0, tbl[i][6:0], 8'h40, 16'h0);
			chk(rsp_nack, 1'b0);
		end
	endtask : t_addr

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{rst_n, stream_mode, sample_tick, event_in, alt_variant} = '0;
		{strap_is_input, strap_drive, strap_gnd, load_en, cmd_valid} = '0;
		{cmd_rw, cmd_new_addr, cmd_dev, cmd_addr, cmd_wdata, load_addr, load_data} = '0;
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		t_write_forced();
		t_reads();
		t_stream();
		t_addr();
		tally_and_finish();
	end
endmodule : testbench
